// file: inc/dcto_chan_if.sv
`default_nettype none

// one safety channel as seen by the monitor
interface dcto_chan_if;
    logic present;
    logic recent;
    logic disc_over;
    logic peer_present;

    modport chan (output present, output recent, output disc_over, input peer_present);
    modport mon  (input present, input recent, input disc_over, output peer_present);
endinterface

`default_nettype wire

// file: inc/dcto_pkg.sv
`default_nettype none

package dcto_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_STOP, ST_TRIP} dcto_state_t;
    typedef logic [15:0] dcto_speed_t;
endpackage

`default_nettype wire

// file: inc/dcto_regs.svh
`ifndef DCTO_REGS_SVH
`define DCTO_REGS_SVH

// ------------------------------
// register offsets (byte addresses, one aligned word each)
// ------------------------------
`define DCTO_OFF_CTRL      8'h00
`define DCTO_OFF_SETPT     8'h04
`define DCTO_OFF_STATUS    8'h08
`define DCTO_OFF_IRQ_STAT  8'h0c
`define DCTO_OFF_IRQ_MASK  8'h10
`define DCTO_OFF_SPEED     8'h14

// ------------------------------
// field positions
// ------------------------------
`define DCTO_CTRL_RUN      0
`define DCTO_CTRL_RESTART  1
`define DCTO_ST_CHAN_A     0
`define DCTO_ST_CHAN_B     1
`define DCTO_ST_TORQUE     2
`define DCTO_ST_TRIP       3
`define DCTO_ST_LATCH      4
`define DCTO_ST_FEEDBACK   5
`define DCTO_ST_RUNNING    6
`define DCTO_EV_TRIP       0
`define DCTO_EV_LATCH      1
`define DCTO_EV_FEEDBACK   2
`define DCTO_EV_STOPPED    3
`define DCTO_EV_W          4

// ------------------------------
// reset values
// ------------------------------
`define DCTO_RST_CTRL      1'b0
`define DCTO_RST_SETPT     16'h0000
`define DCTO_RST_MASK      4'h0

// ------------------------------
// timing
// ------------------------------
`define DCTO_CLK_HZ        25000000
`define DCTO_DISC_MS       3000
`define DCTO_SIMUL_MS      1000
`define DCTO_RESP_US       10000
`define DCTO_RAMP_US       1000
`define DCTO_DISC_CYC      ((`DCTO_CLK_HZ / 1000) * `DCTO_DISC_MS)
`define DCTO_SIMUL_CYC     ((`DCTO_CLK_HZ / 1000) * `DCTO_SIMUL_MS)
`define DCTO_RESP_CYC      ((`DCTO_CLK_HZ / 1000000) * `DCTO_RESP_US)
`define DCTO_RAMP_CYC      ((`DCTO_CLK_HZ / 1000000) * `DCTO_RAMP_US)
`define DCTO_RAMP_STEP     16

`endif

// file: verif/dcto_safety_monitor.sv
`default_nettype none

module dcto_safety_chk #(
    parameter int DISC_CYC = 300
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        chan_a_enable_in_i,
    input wire logic        chan_b_enable_in_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        torque_en_o,
    input wire logic [15:0] speed_o,
    input wire logic        torque_off_feedback_out_o,
    input wire logic        trip_o,
    input wire logic        fault_latch_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic a  = chan_a_enable_in_i;
    wire logic b  = chan_b_enable_in_i;
    wire logic fb = torque_off_feedback_out_o;
    int        disc_q;

    // ------------------------------
    // single-channel absence counter
    // ------------------------------
    // counts raw pins, so the limit below allows for sync and state delay
    always_ff @(posedge clk_i) begin
        if (rst_i || a == b) begin
            disc_q <= 0;
        end else if (disc_q < DISC_CYC + 10) begin
            disc_q <= disc_q + 1;
        end
    end

    // ------------------------------
    // properties
    // ------------------------------
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_both_drop;
        $fell(a) && $fell(b);
    endsequence
    sequence s_both_gone;
        (!a && !b) [*5];
    endsequence

    AST_ACK_PULSE: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one pulse");
    AST_A_LOSS_TRIP: assert property (
        torque_en_o && b && $fell(a) |-> ##[1:4] (!torque_en_o && trip_o && speed_o == 16'h0))
        else $error("a loss no trip");
    AST_B_LOSS_TRIP: assert property (
        torque_en_o && a && $fell(b) |-> ##[1:4] (!torque_en_o && trip_o && speed_o == 16'h0))
        else $error("b loss no trip");
    AST_FB_ONE_PRESENT: assert property ((a || b) [*6] |-> !fb)
        else $error("feedback with a channel on");
    AST_FB_SET: assert property (s_both_drop ##1 s_both_gone |=> fb)
        else $error("no feedback on dual loss");
    AST_FB_CLEAR: assert property ($rose(a && b) |-> ##[1:4] !fb)
        else $error("feedback stuck");
    AST_NO_TORQUE_DUAL: assert property ((!a && !b) [*4] |-> !torque_en_o)
        else $error("torque on, both absent");
    AST_LATCH_STICKY: assert property (
        fault_latch_o |=> fault_latch_o && trip_o && !torque_en_o)
        else $error("latch not sticky");
    AST_LATCH_SET: assert property (disc_q == DISC_CYC + 10 |-> fault_latch_o)
        else $error("latch not set");
endmodule // dcto_safety_chk

bind dcto_monitor dcto_safety_chk #(.DISC_CYC(DISC_CYC)) u_safety_chk (
    .clk_i(clk_i), .rst_i(rst_i), .chan_a_enable_in_i(chan_a_enable_in_i),
    .chan_b_enable_in_i(chan_b_enable_in_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .torque_en_o(torque_en_o), .speed_o(speed_o), .trip_o(trip_o),
    .torque_off_feedback_out_o(torque_off_feedback_out_o), .fault_latch_o(fault_latch_o));

`default_nettype wire

// file: verif/dcto_scu_model.sv
`default_nettype none

module dcto_scu_model #(
    parameter int LAG_CYC = 40
) (
    input  wire logic clk_i,
    input  wire logic demand_a_i,
    input  wire logic demand_b_i,
    input  wire logic slow_i,
    output logic      chan_a_o,
    output logic      chan_b_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int lag_q;

    // channel a opens a clock after demand
    always_ff @(posedge clk_i) begin
        chan_a_o <= !demand_a_i;
    end

    // slow unit opens b late, inside the window
    always_ff @(posedge clk_i) begin
        if (!demand_b_i) begin
            lag_q    <= 0;
            chan_b_o <= 1'b1;
        end else if (!slow_i || lag_q == LAG_CYC) begin
            chan_b_o <= 1'b0;
        end else begin
            lag_q <= lag_q + 1;
        end
    end
endmodule // dcto_scu_model

`default_nettype wire

// file: verif/dual_channel_torque_off_monitor_tb.sv
`include "dcto_regs.svh"
`default_nettype none

module dual_channel_torque_off_monitor_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int          DISC = 300;
    localparam int          LAG  = 40;
    localparam logic [15:0] SPT  = 16'h0040;
    logic        clk_i, rst_i, dem_a, dem_b, slow, ch_a, ch_b;
    logic        wb_cyc, wb_stb, wb_we, wb_ack, ten, fb, trip, latch, irq;
    logic [7:0]  wb_adr;
    logic [31:0] wb_dw, wb_dr, q;
    logic [15:0] spd;
    int          err_count, comparisons;

    always #20 clk_i = ~clk_i;

    dcto_monitor #(.SIMUL_CYC(100), .DISC_CYC(DISC), .RAMP_CYC(4)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .chan_a_enable_in_i(ch_a), .chan_b_enable_in_i(ch_b),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(4'hf), .wb_dat_i(wb_dw), .wb_dat_o(wb_dr), .wb_ack_o(wb_ack),
        .torque_en_o(ten), .speed_o(spd), .torque_off_feedback_out_o(fb), .trip_o(trip),
        .fault_latch_o(latch), .irq_o(irq));
    dcto_scu_model #(.LAG_CYC(LAG)) u_scu (.clk_i(clk_i), .demand_a_i(dem_a),
        .demand_b_i(dem_b), .slow_i(slow), .chan_a_o(ch_a), .chan_b_o(ch_b));

    // ------------------------------
    // bus, wait and compare tasks
    // ------------------------------
    task automatic summarize();
        $display("comparisons %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic timeout(input string n);
        err_count++;
        $display("Error %s expected done seen timeout", n);
        summarize();
    endtask
    task automatic chk_bit(input string n, input logic s, input logic e);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %b seen %b", n, e, s);
        end
    endtask
    task automatic chk_word(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // one classic cycle, bounded wait for ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= w;
        wb_adr <= a;
        wb_dw  <= d;
        for (i = 0; i < 16 && wb_ack !== 1'b1; i++) @(posedge clk_i);
        q = wb_dr;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
        if (i == 16) timeout("bus ack");
    endtask
    task automatic wait_spd(input logic [15:0] e);
        int i;
        for (i = 0; i < 2000 && spd !== e; i++) @(posedge clk_i);
        if (spd !== e) timeout("speed");
    endtask
    task automatic start();
        wb(1'b1, `DCTO_OFF_SETPT, {16'h0, SPT});
        wb(1'b1, `DCTO_OFF_CTRL, 32'h1);
        wait_spd(SPT);
    endtask

    // ------------------------------
    // scenarios
    // ------------------------------
    task automatic t_power_up();
        tick(8);
        chk_bit("feedback", fb, 1'b0);
        chk_bit("trip", trip, 1'b0);
        wb(1'b0, `DCTO_OFF_STATUS, 32'h0);
        chk_word("status", q, 32'h3);
        wb(1'b0, `DCTO_OFF_IRQ_MASK, 32'h0);
        chk_word("irq mask", q, 32'h0);
        wb(1'b0, 8'h1c, 32'h0);
        chk_word("unmapped", q, 32'h0);
    endtask
    task automatic t_run();
        start();
        chk_bit("torque", ten, 1'b1);
        wb(1'b0, `DCTO_OFF_SPEED, 32'h0);
        chk_word("speed reg", q, {16'h0, SPT});
        chk_bit("feedback", fb, 1'b0);
    endtask
    task automatic t_brief(input logic on_b);
        wb(1'b1, `DCTO_OFF_IRQ_MASK, 32'h1);
        dem_a <= !on_b;
        dem_b <= on_b;
        tick(8);
        chk_bit("torque", ten, 1'b0);
        chk_bit("trip", trip, 1'b1);
        chk_bit("feedback", fb, 1'b0);
        chk_bit("irq", irq, 1'b1);
        tick(12);
        dem_a <= 1'b0;
        dem_b <= 1'b0;
        wb(1'b0, `DCTO_OFF_IRQ_STAT, 32'h0);
        chk_bit("trip event", q[0], 1'b1);
        tick(3);
        chk_bit("irq cleared", irq, 1'b0);
        wb(1'b1, `DCTO_OFF_IRQ_MASK, 32'h0);
        wb(1'b1, `DCTO_OFF_CTRL, 32'h3);
        wait_spd(SPT);
        chk_bit("trip", trip, 1'b0);
    endtask
    task automatic t_latch(input logic on_b);
        dem_a <= !on_b;
        dem_b <= on_b;
        tick(DISC + 20);
        chk_bit("latch", latch, 1'b1);
        chk_bit("irq masked", irq, 1'b0);
        dem_a <= 1'b0;
        dem_b <= 1'b0;
        tick(8);
        wb(1'b1, `DCTO_OFF_CTRL, 32'h3);
        tick(20);
        chk_bit("torque", ten, 1'b0);
        chk_bit("trip", trip, 1'b1);
        chk_bit("feedback", fb, 1'b0);
        rst_i <= 1'b1;
        tick(5);
        rst_i <= 1'b0;
        tick(8);
        chk_bit("latch", latch, 1'b0);
        start();
        chk_bit("feedback", fb, 1'b0);
    endtask
    task automatic t_dual(input logic slow_v);
        int i;
        logic [31:0] bad;
        bad = 32'h0;
        slow  <= slow_v;
        dem_a <= 1'b1;
        dem_b <= 1'b1;
        tick(slow_v ? LAG + 10 : 10);
        chk_bit("feedback", fb, 1'b1);
        chk_bit("trip", trip, 1'b1);
        wb(1'b1, `DCTO_OFF_CTRL, 32'h3);
        // run refused, feedback held high through the absence
        for (i = 0; i < 400; i++) begin
            @(posedge clk_i);
            if (ten !== 1'b0 || fb !== 1'b1) bad++;
        end
        chk_word("bad cycles", bad, 32'h0);
        dem_a <= 1'b0;
        dem_b <= 1'b0;
        tick(7);
        chk_bit("feedback", fb, 1'b0);
        chk_bit("trip", trip, 1'b1);
        wb(1'b1, `DCTO_OFF_CTRL, 32'h3);
        wait_spd(SPT);
        chk_bit("trip", trip, 1'b0);
    endtask
    task automatic t_stop();
        wb(1'b1, `DCTO_OFF_CTRL, 32'h0);
        tick(2);
        chk_bit("ramping", spd != 16'h0, 1'b1);
        wait_spd(16'h0);
        tick(4);
        chk_bit("trip", trip, 1'b0);
        chk_bit("feedback", fb, 1'b0);
        wb(1'b0, `DCTO_OFF_IRQ_STAT, 32'h0);
        chk_bit("stop event", q[3], 1'b1);
    endtask

    // main sequence
    initial begin
        clk_i  = 1'b0;
        rst_i  = 1'b1;
        dem_a  = 1'b0;
        dem_b  = 1'b0;
        slow   = 1'b0;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we  = 1'b0;
        wb_adr = 8'h0;
        wb_dw  = 32'h0;
        tick(5);
        rst_i <= 1'b0;
        t_power_up();
        t_run();
        t_brief(1'b0);
        t_brief(1'b1);
        t_latch(1'b0);
        t_latch(1'b1);
        t_dual(1'b0);
        t_dual(1'b1);
        t_stop();
        summarize();
    end
endmodule // dual_channel_torque_off_monitor_tb

`default_nettype wire

// file: verilog/dcto_chan.sv
`include "dcto_regs.svh"
`default_nettype none

module dcto_chan #(
    parameter int SIMUL_CYC = `DCTO_SIMUL_CYC,
    parameter int DISC_CYC  = `DCTO_DISC_CYC
) (
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    input  wire logic   enable_in_i,
    dcto_chan_if.chan   ch
);
    localparam int EW = $clog2(SIMUL_CYC + 2);
    localparam int DW = $clog2(DISC_CYC + 2);
    localparam logic [EW-1:0] EL_MAX = EW'(SIMUL_CYC + 1);
    localparam logic [DW-1:0] DI_MAX = DW'(DISC_CYC + 1);

    logic          sync1_q;
    logic          sync2_q;
    logic [EW-1:0] elapsed_q;
    logic [DW-1:0] disc_q;

    // two-stage synchroniser, resets to absent so the safe state wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= enable_in_i;
            sync2_q <= sync1_q;
        end
    end

    // time since this channel dropped, saturating just past the window
    always_ff @(posedge clk_i) begin
        if (rst_i || sync2_q) begin
            elapsed_q <= '0;
        end else if (elapsed_q != EL_MAX) begin
            elapsed_q <= elapsed_q + 1'b1;
        end
    end

    // discrepancy time: only counts while the peer is still present
    always_ff @(posedge clk_i) begin
        if (rst_i || sync2_q || !ch.peer_present) begin
            disc_q <= '0;
        end else if (disc_q != DI_MAX) begin
            disc_q <= disc_q + 1'b1;
        end
    end

    assign ch.present   = sync2_q;
    assign ch.recent    = !sync2_q && (elapsed_q < EL_MAX);
    assign ch.disc_over = (disc_q == DI_MAX);
endmodule // dcto_chan

`default_nettype wire

// file: verilog/dcto_monitor.sv
// Operation
// - after power-up with both enables present: no error, feedback low
// - both enables present plus run with setpoint: torque on, run at setpoint
// - brief channel A loss: torque off at once, trip flagged, feedback low
// - brief channel B loss: torque off at once, trip flagged, feedback low
// - both enables back plus restart: trip clears, runs at setpoint again
// - single channel absent beyond discrepancy limit sets a torque-off latch
// - latch set: restart refused, trip persists, feedback stays low
// - latch clears only by power-on reset; then restart works, feedback low
// - both enables removed within the window: feedback output asserted
// - both absent: run refused, trip flagged at once, feedback held high
// - both enables reasserted: feedback drops three clocks later, once the enables are synchronised
// - after dual removal and return, restart clears trip and resumes running
// - normal stop with enables present: ramp to rest, no trip, feedback low
// - torque removed well within the response limit after torque-off
`include "dcto_regs.svh"
`default_nettype none

module dcto_monitor
    import dcto_pkg::*;
#(
    parameter int SIMUL_CYC = `DCTO_SIMUL_CYC,
    parameter int DISC_CYC  = `DCTO_DISC_CYC,
    parameter int RAMP_CYC  = `DCTO_RAMP_CYC,
    parameter int RAMP_STEP = `DCTO_RAMP_STEP
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        chan_a_enable_in_i,
    input  wire logic        chan_b_enable_in_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             torque_en_o,
    output logic      [15:0] speed_o,
    output logic             torque_off_feedback_out_o,
    output logic             trip_o,
    output logic             fault_latch_o,
    output logic             irq_o
);
    // ------------------------------
    // helpers
    // ------------------------------
    localparam int RW = $clog2(RAMP_CYC + 1);
    localparam dcto_speed_t STEP = 16'(RAMP_STEP);

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr[7:2] == off[7:2]);
    endfunction

    // ------------------------------------------------------------------
    // channel front ends
    // ------------------------------------------------------------------
    logic [1:0] en_in;
    logic [1:0] present;
    logic [1:0] recent;
    logic [1:0] disc_over;

    assign en_in = {chan_b_enable_in_i, chan_a_enable_in_i};

    dcto_chan_if chif[2] ();

    for (genvar i = 0; i < 2; i++) begin : g_chan
        dcto_chan #(
            .SIMUL_CYC (SIMUL_CYC),
            .DISC_CYC  (DISC_CYC)
        ) u_chan (
            .clk_i       (clk_i),
            .rst_i       (rst_i),
            .enable_in_i (en_in[i]),
            .ch          (chif[i])
        );
        // each channel's discrepancy timer watches the other one
        assign chif[i].peer_present = chif[1-i].present;
        assign present[i]   = chif[i].present;
        assign recent[i]    = chif[i].recent;
        assign disc_over[i] = chif[i].disc_over;
    end

    logic torque_off;
    assign torque_off = !(present[0] && present[1]);

    // ------------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------------
    logic        ack_q;
    logic        acc;
    logic        wr;
    logic        rd;
    logic        run_q;
    logic        run_prev_q;
    logic        restart_q;
    dcto_speed_t setpt_q;
    logic [`DCTO_EV_W-1:0] mask_q;
    logic [`DCTO_EV_W-1:0] istat_q;
    logic [31:0] rdata;
    dcto_state_t state_q;
    dcto_speed_t speed_q;
    logic        trip_q;
    logic        latch_q;
    logic        fb_q;
    logic        torque_q;

    // access completes at the edge where ack is already high
    assign acc = wb_cyc_i && wb_stb_i && ack_q;
    assign wr  = acc && wb_we_i;
    assign rd  = acc && !wb_we_i;

    // one wait state, ack for exactly one cycle per request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
        end
    end

    // read mux; unmapped offsets read as zero
    always_comb begin
        rdata = 32'h0000_0000;
        if (hit(wb_adr_i, `DCTO_OFF_CTRL)) begin
            rdata[`DCTO_CTRL_RUN] = run_q;
        end else if (hit(wb_adr_i, `DCTO_OFF_SETPT)) begin
            rdata[15:0] = setpt_q;
        end else if (hit(wb_adr_i, `DCTO_OFF_STATUS)) begin
            rdata[`DCTO_ST_CHAN_A]   = present[0];
            rdata[`DCTO_ST_CHAN_B]   = present[1];
            rdata[`DCTO_ST_TORQUE]   = torque_q;
            rdata[`DCTO_ST_TRIP]     = trip_q;
            rdata[`DCTO_ST_LATCH]    = latch_q;
            rdata[`DCTO_ST_FEEDBACK] = fb_q;
            rdata[`DCTO_ST_RUNNING]  = (state_q == ST_RUN);
        end else if (hit(wb_adr_i, `DCTO_OFF_IRQ_STAT)) begin
            rdata[`DCTO_EV_W-1:0] = istat_q;
        end else if (hit(wb_adr_i, `DCTO_OFF_IRQ_MASK)) begin
            rdata[`DCTO_EV_W-1:0] = mask_q;
        end else if (hit(wb_adr_i, `DCTO_OFF_SPEED)) begin
            rdata[15:0] = speed_q;
        end
    end

    // read data captured as ack rises
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_cyc_i && wb_stb_i && !ack_q) begin
            wb_dat_o <= rdata;
        end
    end

    // control registers, byte lanes honoured
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_q     <= `DCTO_RST_CTRL;
            restart_q <= 1'b0;
            setpt_q   <= `DCTO_RST_SETPT;
            mask_q    <= `DCTO_RST_MASK;
        end else begin
            restart_q <= 1'b0;
            if (wr && wb_sel_i[0] && hit(wb_adr_i, `DCTO_OFF_CTRL)) begin
                run_q     <= wb_dat_i[`DCTO_CTRL_RUN];
                restart_q <= wb_dat_i[`DCTO_CTRL_RESTART];
            end
            if (wr && hit(wb_adr_i, `DCTO_OFF_SETPT)) begin
                if (wb_sel_i[0]) setpt_q[7:0]  <= wb_dat_i[7:0];
                if (wb_sel_i[1]) setpt_q[15:8] <= wb_dat_i[15:8];
            end
            if (wr && wb_sel_i[0] && hit(wb_adr_i, `DCTO_OFF_IRQ_MASK)) begin
                mask_q <= wb_dat_i[`DCTO_EV_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // run command and ramp tick
    // ------------------------------------------------------------------
    logic          start;
    logic          ramp_tick_q;
    logic [RW-1:0] ramp_cnt_q;

    // a fresh run command is a rising run bit or restart with run held
    assign start = (run_q && !run_prev_q) || (restart_q && run_q);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_prev_q <= 1'b0;
        end else begin
            run_prev_q <= run_q;
        end
    end

    // ramp divider: one-cycle enable every RAMP_CYC clocks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ramp_cnt_q  <= '0;
            ramp_tick_q <= 1'b0;
        end else begin
            ramp_tick_q <= (ramp_cnt_q == RW'(RAMP_CYC - 1));
            if (ramp_cnt_q == RW'(RAMP_CYC - 1)) begin
                ramp_cnt_q <= '0;
            end else begin
                ramp_cnt_q <= ramp_cnt_q + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // fault latch and feedback
    // ------------------------------------------------------------------
    // only the power-on reset clears it; no register write can
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_q <= 1'b0;
        end else if (|disc_over) begin
            latch_q <= 1'b1;
        end
    end

    // feedback only when both dropped inside the window
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fb_q <= 1'b0;
        end else if (present[0] || present[1]) begin
            fb_q <= 1'b0;
        end else if (recent[0] && recent[1]) begin
            fb_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // drive sequencer
    // ------------------------------------------------------------------
    logic trip_req;

    // torque-off while driving or under a run command trips at once
    assign trip_req = latch_q || (torque_off &&
                      (state_q == ST_RUN || state_q == ST_STOP || run_q));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            trip_q  <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (trip_req) begin
                        state_q <= ST_TRIP;
                        trip_q  <= 1'b1;
                    end else if (start) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (trip_req) begin
                        state_q <= ST_TRIP;
                        trip_q  <= 1'b1;
                    end else if (!run_q) begin
                        state_q <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (trip_req) begin
                        state_q <= ST_TRIP;
                        trip_q  <= 1'b1;
                    end else if (start) begin
                        state_q <= ST_RUN;
                    end else if (speed_q == 16'h0000) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_TRIP: begin
                    // latched faults refuse every restart
                    if (start && !torque_off && !latch_q) begin
                        state_q <= ST_RUN;
                        trip_q  <= 1'b0;
                    end
                end
                default: begin
                    state_q <= ST_TRIP;
                    trip_q  <= 1'b1;
                end
            endcase
        end
    end

    // torque gate: drops the cycle after the synchronised loss
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            torque_q <= 1'b0;
        end else begin
            torque_q <= !torque_off && !latch_q && !trip_req &&
                        (state_q == ST_RUN || state_q == ST_STOP);
        end
    end

    // speed demand: ramps in run and stop, zero (coast) otherwise
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            speed_q <= 16'h0000;
        end else if (state_q == ST_IDLE || state_q == ST_TRIP || trip_req) begin
            speed_q <= 16'h0000;
        end else if (ramp_tick_q) begin
            if (state_q == ST_RUN && speed_q < setpt_q) begin
                speed_q <= (setpt_q - speed_q > STEP) ? speed_q + STEP : setpt_q;
            end else if (state_q == ST_RUN && speed_q > setpt_q) begin
                speed_q <= (speed_q - setpt_q > STEP) ? speed_q - STEP : setpt_q;
            end else if (state_q == ST_STOP) begin
                speed_q <= (speed_q > STEP) ? speed_q - STEP : 16'h0000;
            end
        end
    end

    // ------------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------------
    logic                  trip_prev_q;
    logic                  latch_prev_q;
    logic                  fb_prev_q;
    logic [`DCTO_EV_W-1:0] ev;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trip_prev_q  <= 1'b0;
            latch_prev_q <= 1'b0;
            fb_prev_q    <= 1'b0;
        end else begin
            trip_prev_q  <= trip_q;
            latch_prev_q <= latch_q;
            fb_prev_q    <= fb_q;
        end
    end

    always_comb begin
        ev = '0;
        ev[`DCTO_EV_TRIP]     = trip_q && !trip_prev_q;
        ev[`DCTO_EV_LATCH]    = latch_q && !latch_prev_q;
        ev[`DCTO_EV_FEEDBACK] = fb_q && !fb_prev_q;
        ev[`DCTO_EV_STOPPED]  = (state_q == ST_STOP) && (speed_q == 16'h0000)
                                && !trip_req && !start;
    end

    // read clears; an event in the same cycle still sets
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            istat_q <= '0;
        end else if (rd && hit(wb_adr_i, `DCTO_OFF_IRQ_STAT)) begin
            istat_q <= ev;
        end else begin
            istat_q <= istat_q | ev;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |((istat_q | ev) & mask_q);
        end
    end

    // ------------------------------
    // outputs
    // ------------------------------
    assign wb_ack_o                  = ack_q;
    assign torque_en_o               = torque_q;
    assign speed_o                   = speed_q;
    assign torque_off_feedback_out_o = fb_q;
    assign trip_o                    = trip_q;
    assign fault_latch_o             = latch_q;
endmodule // dcto_monitor

`default_nettype wire
